// [logic/dpr_top.sv]
// Debug power request mode, system-off wake and automatic power manager
module dpr_top #(
   parameter int unsigned PRIO_BITS = dpr_pkg::PRIO_BITS,
   parameter int unsigned NUM_COMP  = dpr_pkg::NUM_COMP
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic                 debug_power_request,
   input  wire logic                 wake_detect_pin,
   input  wire logic                 system_off_req,
   input  wire logic                 debug_wake_flag_clear,
   input  wire logic                 halt_req,
   input  wire logic                 resume_req,
   input  wire logic [PRIO_BITS-1:0] exec_priority,
   input  wire logic                 irq_pending,
   input  wire logic [PRIO_BITS-1:0] irq_priority,
   input  wire logic [NUM_COMP-1:0]  comp_clock_req,
   input  wire logic [NUM_COMP-1:0]  comp_supply_req,
   output logic                      system_on,
   output logic                      debug_mode,
   output logic                      debug_power_ack,
   output logic                      debug_wake_flag,
   output logic                      core_halted,
   output logic                      irq_service_grant,
   output logic                      regulator_on,
   output logic                      regulator_low_power,
   output logic                      hf_clock_on
);
   localparam int unsigned WAKE_W = $clog2(dpr_pkg::WAKE_CYCLES + 1);
   localparam logic [WAKE_W-1:0] WAKE_LAST =
      WAKE_W'(dpr_pkg::WAKE_CYCLES - 1);
   localparam int unsigned CNT_W = $clog2(NUM_COMP + 1);
   localparam logic [CNT_W-1:0] LP_MAX = CNT_W'(dpr_pkg::LP_THRESHOLD);

   dpr_sync_if pins ();
   assign pins.raw_power_request = debug_power_request;
   assign pins.raw_wake_pin      = wake_detect_pin;

   dpr_sync u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pins    (pins)
   );

   dpr_pkg::dpr_state_t state;
   dpr_pkg::dpr_state_t next_state;
   logic [WAKE_W-1:0]   wake_count;
   logic                dbg_req;
   logic [PRIO_BITS-1:0] halt_priority;
   logic [CNT_W-1:0]    active_count;

   assign dbg_req = pins.power_request;

   // System-off state: wake by debug request or wake pin
   always_comb begin
      next_state = state;
      unique case (state)
         dpr_pkg::DPR_ST_ON: begin
            if (system_off_req && !dbg_req) begin
               next_state = dpr_pkg::DPR_ST_OFF;
            end
         end
         dpr_pkg::DPR_ST_OFF: begin
            if (dbg_req || pins.wake_pin) begin
               next_state = dpr_pkg::DPR_ST_WAKE; // RQ2
            end
         end
         dpr_pkg::DPR_ST_WAKE: begin
            if (wake_count == WAKE_LAST) begin
               next_state = dpr_pkg::DPR_ST_ON;
            end
         end
         default: next_state = dpr_pkg::DPR_ST_OFF;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dpr_pkg::DPR_ST_ON;
      end else begin
         state <= next_state;
      end
   end

   // Wake-up delay counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_count <= '0;
      end else if (state == dpr_pkg::DPR_ST_WAKE) begin
         wake_count <= wake_count + WAKE_W'(1);
      end else begin
         wake_count <= '0;
      end
   end

   // Sticky wake cause flag, set wins over clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_wake_flag <= dpr_pkg::WAKE_FLAG_RST;
      end else if (state == dpr_pkg::DPR_ST_OFF && dbg_req) begin
         debug_wake_flag <= 1'b1; // RQ2
      end else if (debug_wake_flag_clear) begin
         debug_wake_flag <= 1'b0;
      end
   end

   // Debug interface mode follows the held request while powered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_mode      <= dpr_pkg::MODE_RST;
         debug_power_ack <= 1'b0;
         system_on       <= 1'b1;
      end else begin
         system_on       <= (next_state == dpr_pkg::DPR_ST_ON);
         debug_mode      <= dbg_req
                            && next_state == dpr_pkg::DPR_ST_ON; // RQ3 RQ4
         // Ack gates access port traffic until power is granted
         debug_power_ack <= dbg_req
                            && next_state == dpr_pkg::DPR_ST_ON; // RQ1 RQ5
      end
   end

   // Halt tracking and real-time interrupt service
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_halted   <= 1'b0;
         halt_priority <= '0;
      end else if (!debug_mode || resume_req) begin
         core_halted   <= 1'b0;
      end else if (halt_req && !core_halted) begin
         core_halted   <= 1'b1;
         halt_priority <= exec_priority;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_service_grant <= 1'b0;
      end else begin
         // Lower number means higher priority
         irq_service_grant <= irq_pending
            && (!core_halted || irq_priority < halt_priority); // RQ6
      end
   end

   // Automatic regulator and clock control
   always_comb begin
      active_count = '0;
      for (int i = 0; i < NUM_COMP; i++) begin
         active_count = active_count + CNT_W'(comp_supply_req[i]);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regulator_on        <= 1'b1;
         regulator_low_power <= 1'b0;
         hf_clock_on         <= 1'b0;
      end else if (next_state != dpr_pkg::DPR_ST_ON) begin
         regulator_on        <= next_state == dpr_pkg::DPR_ST_WAKE;
         regulator_low_power <= 1'b0;
         hf_clock_on         <= 1'b0;
      end else begin
         regulator_on        <= 1'b1; // RQ7
         regulator_low_power <= !dbg_req
                                && active_count <= LP_MAX; // RQ7
         hf_clock_on         <= dbg_req || |comp_clock_req; // RQ7
      end
   end
endmodule // dpr_top

// [logic/dpr_pkg.sv]
// Package of constants and types for the debug power request block
// Contract
// [RQ1] Debugger raises the power request before touching any access port.
// [RQ2] Power request during system-off wakes device and sets debug wake flag.
// [RQ3] Device stays in debug interface mode while the request is held.
// [RQ4] Dropping the request returns the device to normal mode at once. The code leaves debug mode three ref_clk cycles after the request falls.
// [RQ5] Debugger drops its request when the session ends, to save power.
// [RQ6] While halted, higher priority interrupts still run to completion.
// [RQ7] Power manager starts, stops and picks regulator and clock modes itself.
// [RQ8] Power request is synchronised to the system clock before use.
package dpr_pkg;
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned WAKE_TIME_NS  = 1000;
   localparam int unsigned WAKE_CYCLES   =
      (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned PRIO_BITS     = 3;
   localparam int unsigned NUM_COMP      = 4;
   localparam int unsigned LP_THRESHOLD  = 1;
   localparam logic        WAKE_FLAG_RST = 1'b0;
   localparam logic        MODE_RST      = 1'b0;

   typedef enum logic [1:0] {
      DPR_ST_ON   = 2'b00,
      DPR_ST_OFF  = 2'b01,
      DPR_ST_WAKE = 2'b11
   } dpr_state_t;
endpackage

// [logic/dpr_sync_if.sv]
// Carrier for synchronised pin levels between the synchroniser and the core
interface dpr_sync_if;
   logic raw_power_request;
   logic raw_wake_pin;
   logic power_request;
   logic wake_pin;
   modport sync (input raw_power_request, input raw_wake_pin,
                 output power_request, output wake_pin);
   modport core (output raw_power_request, output raw_wake_pin,
                 input power_request, input wake_pin);
endinterface

// [logic/dpr_sync.sv]
// Two-stage synchroniser for the asynchronous pin levels
module dpr_sync (
   input wire logic ref_clk,
   input wire logic rst_n,
   dpr_sync_if.sync pins
);
   logic [1:0] stage1;
   logic [1:0] stage2;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 2'h0;
         stage2 <= 2'h0;
      end else begin
         stage1 <= {pins.raw_wake_pin, pins.raw_power_request}; // RQ8
         stage2 <= stage1;
      end
   end

   assign pins.power_request = stage2[0];
   assign pins.wake_pin      = stage2[1];
endmodule // dpr_sync

// [verification/dpr_assertions.sv]
// Checker of the debug power request block ports
module dpr_assertions (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic debug_power_request,
   input wire logic system_off_req,
   input wire logic system_on,
   input wire logic debug_mode,
   input wire logic debug_power_ack,
   input wire logic debug_wake_flag,
   input wire logic hf_clock_on
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_mode_rise: assert property ($rose(debug_power_request) &&
      system_on && !debug_mode |-> !debug_mode[*3] ##1 debug_mode)
      else $error("mode rise");
   chk_mode_fall: assert property ($fell(debug_power_request) &&
      system_on && debug_mode |-> debug_mode[*3] ##1 !debug_mode)
      else $error("mode fall");
   chk_ack_mode: assert property (debug_power_ack == debug_mode)
      else $error("ack differs");
   chk_off_refused: assert property (debug_mode && system_off_req &&
      $past(debug_power_request, 2) |=> system_on) else $error("off taken");
   chk_wake_flag: assert property (!system_on && !debug_wake_flag &&
      $rose(debug_power_request) |-> ##3 debug_wake_flag) else $error("flag");
   chk_flag_off: assert property ($rose(debug_wake_flag) |-> !system_on)
      else $error("flag in on");
   chk_wake_time: assert property ($rose(debug_wake_flag) |->
      ##[199:201] $rose(system_on)) else $error("wake time");
   chk_debug_clock: assert property (debug_mode |-> hf_clock_on)
      else $error("clock off");
endmodule // dpr_assertions
bind dpr_top dpr_assertions dpr_assertions_i (
   .ref_clk             (ref_clk),
   .rst_n               (rst_n),
   .debug_power_request (debug_power_request),
   .system_off_req      (system_off_req),
   .system_on           (system_on),
   .debug_mode          (debug_mode),
   .debug_power_ack     (debug_power_ack),
   .debug_wake_flag     (debug_wake_flag),
   .hf_clock_on         (hf_clock_on)
);

// [verification/dpr_probe.sv]
// Debugger probe model on the debug port
module dpr_probe (
   input wire logic ref_clk,
   input wire logic session,
   input wire logic debug_power_ack,
   output logic     debug_power_request,
   output int       access_count
);
   timeunit 1ns;
   timeprecision 100ps;
   initial debug_power_request = 1'b0;
   initial access_count = 0;
   always @(posedge ref_clk) begin
      debug_power_request <= session;
      if (session && debug_power_ack)
         access_count <= access_count + 1;
   end
endmodule // dpr_probe

// [verification/dpr_top_tb.sv]
// Testbench of the debug power request block
module dpr_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0, rst_n = 1'b0, session = 1'b0;
   logic system_off_req = 1'b0, debug_wake_flag_clear = 1'b0;
   logic halt_req = 1'b0, resume_req = 1'b0, irq_pending = 1'b0;
   logic wake_detect_pin = 1'b0;
   logic [2:0] exec_priority = 3'h4, irq_priority = 3'h2;
   logic [3:0] comp_clock_req = 4'h0, comp_supply_req = 4'h0;
   logic debug_power_request, system_on, debug_mode, debug_power_ack;
   logic debug_wake_flag, core_halted, irq_service_grant, hf_clock_on;
   logic regulator_on, regulator_low_power;
   int   access_count, failures = 0, checked = 0;
   always #2.5 ref_clk = ~ref_clk;
   dpr_probe dpr_probe_i (
      .ref_clk             (ref_clk),
      .session             (session),
      .debug_power_ack     (debug_power_ack),
      .debug_power_request (debug_power_request),
      .access_count        (access_count)
   );
   dpr_top dpr_top_i (
      .ref_clk               (ref_clk),
      .rst_n                 (rst_n),
      .debug_power_request   (debug_power_request),
      .wake_detect_pin       (wake_detect_pin),
      .system_off_req        (system_off_req),
      .debug_wake_flag_clear (debug_wake_flag_clear),
      .halt_req              (halt_req),
      .resume_req            (resume_req),
      .exec_priority         (exec_priority),
      .irq_pending           (irq_pending),
      .irq_priority          (irq_priority),
      .comp_clock_req        (comp_clock_req),
      .comp_supply_req       (comp_supply_req),
      .system_on             (system_on),
      .debug_mode            (debug_mode),
      .debug_power_ack       (debug_power_ack),
      .debug_wake_flag       (debug_wake_flag),
      .core_halted           (core_halted),
      .irq_service_grant     (irq_service_grant),
      .regulator_on          (regulator_on),
      .regulator_low_power   (regulator_low_power),
      .hf_clock_on           (hf_clock_on)
   );
   task automatic cyc(int k);
      repeat (k) @(negedge ref_clk);
   endtask
   task automatic chk(string s, logic e, logic g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic pulse(ref logic p);
      p = 1'b1;
      cyc(1);
      p = 1'b0;
      cyc(1);
   endtask
   task automatic sess(logic v);
      session = v;
      cyc(3);
      chk("early mode", !v, debug_mode);
      cyc(1);
      chk("mode", v, debug_mode);
      chk("ack", v, debug_power_ack);
   endtask
   task automatic t_mode;
      chk("low power", 1'b1, regulator_low_power);
      sess(1'b1);
      chk("low power", 1'b0, regulator_low_power);
      chk("debug clock", 1'b1, hf_clock_on);
      system_off_req = 1'b1;
      cyc(20);
      system_off_req = 1'b0;
      chk("off refused", 1'b1, system_on);
      chk("access", 1'b1, access_count > 0);
      sess(1'b0);
      comp_supply_req = 4'h3;
      comp_clock_req = 4'h2;
      cyc(1);
      chk("busy low power", 1'b0, regulator_low_power);
      chk("comp clock", 1'b1, hf_clock_on);
      comp_supply_req = 4'h1;
      comp_clock_req = 4'h0;
      cyc(1);
      chk("one low power", 1'b1, regulator_low_power);
      chk("idle clock", 1'b0, hf_clock_on);
      comp_supply_req = 4'h0;
   endtask
   task automatic t_wake;
      pulse(system_off_req);
      chk("off", 1'b0, system_on);
      chk("off regulator", 1'b0, regulator_on);
      chk("off clock", 1'b0, hf_clock_on);
      session = 1'b1;
      cyc(4);
      chk("wake flag", 1'b1, debug_wake_flag);
      chk("wake regulator", 1'b1, regulator_on);
      cyc(dpr_pkg::WAKE_CYCLES - 2);
      chk("waking", 1'b0, system_on);
      cyc(3);
      chk("woken", 1'b1, system_on);
      pulse(debug_wake_flag_clear);
      chk("flag clear", 1'b0, debug_wake_flag);
      sess(1'b0);
   endtask
   task automatic t_halt;
      pulse(halt_req);
      chk("halt refused", 1'b0, core_halted);
      sess(1'b1);
      pulse(halt_req);
      irq_pending = 1'b1;
      cyc(2);
      chk("grant", 1'b1, irq_service_grant);
      irq_priority = 3'h5;
      cyc(2);
      chk("no grant", 1'b0, irq_service_grant);
      pulse(resume_req);
      chk("resumed", 1'b0, core_halted);
      chk("free grant", 1'b1, irq_service_grant);
      sess(1'b0);
   endtask
   task automatic t_pin_wake;
      pulse(system_off_req);
      chk("pin off", 1'b0, system_on);
      wake_detect_pin = 1'b1;
      cyc(4);
      chk("pin waking", 1'b0, system_on);
      chk("pin regulator", 1'b1, regulator_on);
      cyc(dpr_pkg::WAKE_CYCLES);
      wake_detect_pin = 1'b0;
      chk("pin woken", 1'b1, system_on);
      chk("pin flag", 1'b0, debug_wake_flag);
   endtask
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      cyc(8);
      rst_n = 1'b1;
      cyc(2);
      t_mode;
      t_wake;
      t_halt;
      t_pin_wake;
      final_report;
   end
   initial begin
      #20000;
      failures++;
      final_report;
   end
endmodule // dpr_top_tb
